// ---- dv/ddis_drive_model.sv ----
// Behavioural model of the attached drive behind the control lines
`timescale 1ns/10ps
`default_nettype none
module ddis_drive_model (
    input  wire logic       drive_select_n_i,
    input  wire logic [8:0] head_select_lines_n_i,
    input  wire logic       write_gate_n_i,
    output var  logic       seek_complete_n_o,
    output var  logic       track_zero_n_o,
    output var  logic       write_fault_n_o,
    output var  logic       ready_n_o,
    output var  logic       head_chip_enable_n_o,
    output var  logic       write_read_select_o,
    output var  logic [1:0] binary_head_select_o
);
    logic sel;
    // Status drivers are open collector, so an unselected drive leaves them released high
    always_comb begin
        sel = !drive_select_n_i;
        seek_complete_n_o = !sel;
        track_zero_n_o = !sel;            // Heads parked on the outer track
        write_fault_n_o = 1'b1;           // No head fault is modelled
        ready_n_o = !sel;
    end
    // Head decode; the lowest asserted line wins if several are low
    always_comb begin
        head_chip_enable_n_o = &head_select_lines_n_i;
        write_read_select_o = sel && !write_gate_n_i;
        binary_head_select_o = 2'h0;
        for (int i = 8; i >= 0; i--) begin
            if (!head_select_lines_n_i[i]) binary_head_select_o = i[1:0];
        end
    end
endmodule
`default_nettype wire

// ---- dv/test_ddis_top.sv ----
// Self-checking bench for the drive interface support block
`timescale 1ns/10ps
`default_nettype none
module test_ddis_top;
    import ddis_pkg::*;
    typedef struct packed {logic [7:0] a; logic [31:0] d; logic [1:0] r; logic ds; logic [8:0] hs;}
        ddis_row_s;
    logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic enc = 1'b0, cwd = 1'b0, isn = 1'b1, osn = 1'b1, rd_en = 1'b0, rd_seen = 1'b0;
    logic [7:0] awa = 8'h00, ara = 8'h00, bin = 8'h00;
    logic [31:0] wd = 32'h0;
    logic [1:0] psel = 2'h0;
    logic awr, wr, bv, arr, rv, rclk, rdo, ewp, wclk, refclk, dsn, dsoe, ireq, oreq, boe;
    logic [1:0] brsp, rrsp, bhs, r;
    logic [31:0] rdat, d;
    logic [8:0] hsn, hsoe;
    logic [7:0] bout;
    logic skc, trk, wflt, rdy, hce, wrs, dsw;
    logic [8:0] hsw;
    int fails = 0, total_checks = 0, cyc = 0, n, a, b;
    localparam int PER_EXP [3] = '{DDIS_CORE_HZ / DDIS_WRITE_CLK_HZ,
                                   DDIS_CORE_HZ / DDIS_REF_CLK_HZ, DDIS_CELL_CYCLES};
    // Select writes, an ignored status write and an unmapped address
    ddis_row_s rows [6] = '{
        '{DDIS_OFF_SELECT, 32'h201, DDIS_RESP_OKAY, 1'b0, 9'h1fe},
        '{DDIS_OFF_SELECT, 32'h100, DDIS_RESP_OKAY, 1'b1, 9'h0ff},
        '{DDIS_OFF_STATUS, 32'h3, DDIS_RESP_OKAY, 1'b1, 9'h0ff},
        '{8'h10, 32'h3ff, DDIS_RESP_SLVERR, 1'b1, 9'h0ff},
        '{DDIS_OFF_SELECT, 32'h3ff, DDIS_RESP_OKAY, 1'b0, 9'h000},
        '{DDIS_OFF_SELECT, 32'h0, DDIS_RESP_OKAY, 1'b1, 9'h1ff}};
    // Pull-ups hold released open-collector lines high
    assign dsw = dsoe | dsn;
    assign hsw = hsoe | hsn;
    always #5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    // Raw read stream with one transition per bit cell while enabled
    always @(posedge clk) if (rd_en && cyc % DDIS_CELL_CYCLES == 0) enc <= ~enc;
    always @(negedge clk) if (rdo === 1'b1) rd_seen <= 1'b1;

    ddis_top dut (.CORE_CLK_I(clk), .RST_I(rst), .CE_I(1'b1),
        .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
        .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr),
        .S_AXI_BRESP_O(brsp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bry),
        .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
        .S_AXI_RDATA_O(rdat), .S_AXI_RRESP_O(rrsp), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rry),
        .ENCODED_READ_PAIR_I(enc), .READ_CLOCK_O(rclk), .READ_DATA_O(rdo),
        .CORE_WRITE_DATA_I(cwd), .PRECOMP_SELECT_I(psel), .ENCODED_WRITE_PAIR_O(ewp),
        .WRITE_CLOCK_O(wclk), .REF_CLOCK_O(refclk), .DRIVE_SELECT_N_O(dsn),
        .DRIVE_SELECT_N_OE_O(dsoe), .HEAD_SELECT_LINES_N_O(hsn), .HEAD_SELECT_LINES_N_OE_O(hsoe),
        .INBOUND_DATA_REQUEST_N_O(ireq), .OUTBOUND_DATA_REQUEST_N_O(oreq),
        .INBOUND_DATA_STROBE_N_I(isn), .OUTBOUND_DATA_STROBE_N_I(osn),
        .BYTE_DATA_BUS_I(bin), .BYTE_DATA_BUS_O(bout), .BYTE_DATA_BUS_OE_O(boe));

    ddis_drive_model drive (.drive_select_n_i(dsw), .head_select_lines_n_i(hsw),
        .write_gate_n_i(1'b1), .seek_complete_n_o(skc), .track_zero_n_o(trk),
        .write_fault_n_o(wflt), .ready_n_o(rdy), .head_chip_enable_n_o(hce),
        .write_read_select_o(wrs), .binary_head_select_o(bhs));

    task automatic final_report;
        $display("Checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic stop;
        fails++;
        final_report();
    endtask
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic pick(input int k);
        case (k)
            0: return ireq;
            1: return oreq;
            2: return wclk;
            3: return refclk;
            4: return rclk;
            default: return ewp;
        endcase
    endfunction
    // Counts falling edges until the chosen output shows the wanted level
    task automatic wait_for(input int k, input logic v, output int c);
        for (c = 1; c < 300; c++) begin
            @(negedge clk);
            if (pick(k) === v) return;
        end
        stop();
    endtask
    // Address and data are offered together; each is dropped after its own handshake
    task automatic axw(input logic [7:0] ad, input logic [31:0] dt, output logic [1:0] rs);
        logic ta, tw, na, nw;
        int c;
        @(posedge clk);
        awa <= ad; wd <= dt; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
        ta = 1'b0; tw = 1'b0;
        for (c = 0; c < 50 && !(ta && tw); c++) begin
            @(negedge clk);
            na = awr; nw = wr;
            @(posedge clk);
            if (na === 1'b1) begin awv <= 1'b0; ta = 1'b1; end
            if (nw === 1'b1) begin wv <= 1'b0; tw = 1'b1; end
        end
        for (c = 0; c < 50 && bv !== 1'b1; c++) @(negedge clk);
        if (bv !== 1'b1 || !(ta && tw)) stop();
        rs = brsp;
        @(posedge clk);
        bry <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] ad, output logic [31:0] dt, output logic [1:0] rs);
        int c;
        @(posedge clk);
        ara <= ad; arv <= 1'b1; rry <= 1'b1;
        for (c = 0; c < 50 && arr !== 1'b1; c++) @(negedge clk);
        if (arr !== 1'b1) stop();
        @(posedge clk);
        arv <= 1'b0;
        for (c = 0; c < 50 && rv !== 1'b1; c++) @(negedge clk);
        if (rv !== 1'b1) stop();
        dt = rdat; rs = rrsp;
        @(posedge clk);
        rry <= 1'b0;
    endtask

    initial begin
        @(negedge clk);
        chk({ireq, oreq, dsoe, boe, bv, &hsoe}, 6'b111101);
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        // Register table rows: response, driven lines and the drive's reaction
        foreach (rows[i]) begin
            axw(rows[i].a, rows[i].d, r);
            chk(r, rows[i].r);
            @(negedge clk);
            chk({dsw, hsw}, {rows[i].ds, rows[i].hs});
            chk({skc, rdy, trk, wflt, hce}, {{3{rows[i].ds}}, 1'b1, &rows[i].hs});
        end
        axr(8'h10, d, r);
        chk({r, d}, {DDIS_RESP_SLVERR, 32'h0});
        // Periods of write, reference and recovered read clocks
        rd_en <= 1'b1;
        for (int k = 2; k < 5; k++) begin
            wait_for(k, 1'b0, n);
            wait_for(k, 1'b1, n);
            wait_for(k, 1'b0, a);
            wait_for(k, 1'b1, b);
            chk(a + b, PER_EXP[k-2]);
        end
        chk(rd_seen, 1'b1);
        rd_en <= 1'b0;
        repeat (3 * DDIS_CELL_CYCLES) @(posedge clk);
        @(negedge clk);
        chk(rdo, 1'b0);
        // Bypass: write data follows after one cycle, toggling every cycle
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            cwd <= i[0];
            @(negedge clk);
            if (i > 0) chk(ewp, !i[0]);
        end
        // Tap two adds three cycles to the one-cycle path: seen at the fifth falling edge
        axw(DDIS_OFF_CONTROL, 32'h4, r);
        @(posedge clk);
        psel <= 2'h2;
        cwd <= 1'b0;
        repeat (8) @(posedge clk);
        cwd <= 1'b1;
        wait_for(5, 1'b1, n);
        chk(n, 5);
        // Outbound byte: request, driven bus, strobe, then withdrawal
        axw(DDIS_OFF_DATA, 32'ha5, r);
        axw(DDIS_OFF_CONTROL, 32'h2, r);
        wait_for(1, 1'b0, n);
        chk({boe, bout}, 9'h0a5);
        @(posedge clk);
        osn <= 1'b0;
        @(posedge clk);
        osn <= 1'b1;
        wait_for(1, 1'b1, n);
        axr(DDIS_OFF_STATUS, d, r);
        chk({oreq, boe, d[1]}, 3'b110);
        // Inbound byte: captured on the strobe's trailing edge, request drops until read
        axw(DDIS_OFF_CONTROL, 32'h1, r);
        wait_for(0, 1'b0, n);
        @(posedge clk);
        bin <= 8'h3c;
        isn <= 1'b0;
        @(posedge clk);
        isn <= 1'b1;
        wait_for(0, 1'b1, n);
        @(posedge clk);
        bin <= 8'hc3;
        axr(DDIS_OFF_STATUS, d, r);
        chk({ireq, d[1:0]}, 3'b101);
        axr(DDIS_OFF_DATA, d, r);
        chk(d[7:0], 8'h3c);
        wait_for(0, 1'b0, n);
        // Reset in mid-transfer releases every line
        axw(DDIS_OFF_CONTROL, 32'h3, r);
        axw(DDIS_OFF_DATA, 32'h5a, r);
        wait_for(1, 1'b0, n);
        @(posedge clk);
        rst <= 1'b1;
        @(negedge clk);
        chk({ireq, oreq, dsoe, boe, bv, &hsoe}, 6'b111101);
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk({ireq, oreq}, 2'b11);
        final_report();
    end
endmodule
`default_nettype wire

// ---- rtl/ddis_clkdiv.sv ----
// Toggle divider producing a square clock strobe from the core clock
`timescale 1ns/10ps
`default_nettype none
module ddis_clkdiv #(
    parameter int HALF = 10
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    output var  logic clk_o
);
    localparam int CW = (HALF > 1) ? $clog2(HALF) : 1;
    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          lvl;
    } ddis_div_s;
    ddis_div_s st_r;
    ddis_div_s st_nxt;

    if (HALF < 1) begin : g_half_check
        $error("HALF must be at least one");
    end

    // Count half periods and flip the output at each end
    always_comb begin
        st_nxt = st_r;
        if (st_r.cnt == CW'(HALF - 1)) begin
            st_nxt.cnt = '0;
            st_nxt.lvl = ~st_r.lvl;
        end else begin
            st_nxt.cnt = st_r.cnt + CW'(1);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    assign clk_o = st_r.lvl;

    // Output holds for exactly HALF enabled cycles between flips
    a_div_half_period: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && st_r.cnt == CW'(HALF - 1)) |=> (clk_o != $past(clk_o)))
        else $error("divider missed a flip");
endmodule
`default_nettype wire

// ---- rtl/ddis_pkg.sv ----
// Shared constants for the disc drive interface support block
package ddis_pkg;
    // Register byte offsets
    localparam logic [7:0] DDIS_OFF_SELECT  = 8'h00;
    localparam logic [7:0] DDIS_OFF_DATA    = 8'h04;
    localparam logic [7:0] DDIS_OFF_CONTROL = 8'h08;
    localparam logic [7:0] DDIS_OFF_STATUS  = 8'h0c;
    // Field positions in the select register
    localparam int DDIS_SEL_DRIVE_BIT = 9;
    localparam int DDIS_HEAD_W        = 9;
    // Field positions in the control register
    localparam int DDIS_CTL_INBOUND_BIT  = 0;
    localparam int DDIS_CTL_OUTBOUND_BIT = 1;
    localparam int DDIS_CTL_PRECOMP_BIT  = 2;
    // Reset values
    localparam logic [9:0] DDIS_SELECT_RST  = 10'h000;
    localparam logic [2:0] DDIS_CONTROL_RST = 3'h0;
    // Clock rates and derived divider counts
    localparam int DDIS_CORE_HZ      = 100000000;
    localparam int DDIS_WRITE_CLK_HZ = 5000000;
    localparam int DDIS_REF_CLK_HZ   = 10000000;
    localparam int DDIS_WRITE_HALF   = DDIS_CORE_HZ / (2 * DDIS_WRITE_CLK_HZ);
    localparam int DDIS_REF_HALF     = DDIS_CORE_HZ / (2 * DDIS_REF_CLK_HZ);
    // Read recovery: core cycles per recovered bit cell
    localparam int DDIS_CELL_CYCLES  = DDIS_CORE_HZ / DDIS_REF_CLK_HZ;
    // Precompensation delay in core cycles when enabled at tap zero
    localparam int DDIS_PRECOMP_CYCLES = 1;
    // Bus responses
    localparam logic [1:0] DDIS_RESP_OKAY   = 2'h0;
    localparam logic [1:0] DDIS_RESP_SLVERR = 2'h2;
endpackage

// ---- rtl/ddis_top.sv ----
// Drive interface support: read recovery, select latch, byte DMA, clocks, precomp
`timescale 1ns/10ps
`default_nettype none
module ddis_top
    import ddis_pkg::*;
#(
    parameter int AW = 8
) (
    input  wire logic                 CORE_CLK_I,
    input  wire logic                 RST_I,
    input  wire logic                 CE_I,
    input  wire logic [AW-1:0]        S_AXI_AWADDR_I,
    input  wire logic                 S_AXI_AWVALID_I,
    output var  logic                 S_AXI_AWREADY_O,
    input  wire logic [31:0]          S_AXI_WDATA_I,
    input  wire logic [3:0]           S_AXI_WSTRB_I,
    input  wire logic                 S_AXI_WVALID_I,
    output var  logic                 S_AXI_WREADY_O,
    output var  logic [1:0]           S_AXI_BRESP_O,
    output var  logic                 S_AXI_BVALID_O,
    input  wire logic                 S_AXI_BREADY_I,
    input  wire logic [AW-1:0]        S_AXI_ARADDR_I,
    input  wire logic                 S_AXI_ARVALID_I,
    output var  logic                 S_AXI_ARREADY_O,
    output var  logic [31:0]          S_AXI_RDATA_O,
    output var  logic [1:0]           S_AXI_RRESP_O,
    output var  logic                 S_AXI_RVALID_O,
    input  wire logic                 S_AXI_RREADY_I,
    input  wire logic                 ENCODED_READ_PAIR_I,
    output var  logic                 READ_CLOCK_O,
    output var  logic                 READ_DATA_O,
    input  wire logic                 CORE_WRITE_DATA_I,
    input  wire logic [1:0]           PRECOMP_SELECT_I,
    output var  logic                 ENCODED_WRITE_PAIR_O,
    output var  logic                 WRITE_CLOCK_O,
    output var  logic                 REF_CLOCK_O,
    output var  logic                 DRIVE_SELECT_N_O,
    output var  logic                 DRIVE_SELECT_N_OE_O,
    output var  logic [DDIS_HEAD_W-1:0] HEAD_SELECT_LINES_N_O,
    output var  logic [DDIS_HEAD_W-1:0] HEAD_SELECT_LINES_N_OE_O,
    output var  logic                 INBOUND_DATA_REQUEST_N_O,
    output var  logic                 OUTBOUND_DATA_REQUEST_N_O,
    input  wire logic                 INBOUND_DATA_STROBE_N_I,
    input  wire logic                 OUTBOUND_DATA_STROBE_N_I,
    input  wire logic [7:0]           BYTE_DATA_BUS_I,
    output var  logic [7:0]           BYTE_DATA_BUS_O,
    output var  logic                 BYTE_DATA_BUS_OE_O
);
    if (AW < 4) begin : g_aw_check
        $error("AW too narrow for the register map");
    end

    typedef struct packed {
        logic            aw_got;
        logic            w_got;
        logic [AW-1:0]   aw_addr;
        logic [31:0]     w_data;
        logic [3:0]      w_strb;
        logic            bvalid;
        logic [1:0]      bresp;
        logic            rvalid;
        logic [1:0]      rresp;
        logic [31:0]     rdata;
        logic [9:0]      select;
        logic [2:0]      control;
        logic [7:0]      out_byte;
        logic            out_full;
        logic [7:0]      in_byte;
        logic            in_full;
        logic            in_strb_d;
        logic            out_strb_d;
        logic            rd_prev;
        logic [3:0]      cell_cnt;
        logic            rd_seen;
        logic            rd_clk;
        logic            rd_data;
        logic [2:0]      wr_dly;
        logic            wr_out;
    } ddis_top_s;

    ddis_top_s st_r;
    ddis_top_s st_nxt;
    logic      wr_clk;
    logic      ref_clk;

    // Write timing clock and recovery reference clock
    ddis_clkdiv #(.HALF(DDIS_WRITE_HALF)) u_wr_div (
        .clk_i (CORE_CLK_I),
        .rst_i (RST_I),
        .ce_i  (CE_I),
        .clk_o (wr_clk)
    );
    ddis_clkdiv #(.HALF(DDIS_REF_HALF)) u_ref_div (
        .clk_i (CORE_CLK_I),
        .rst_i (RST_I),
        .ce_i  (CE_I),
        .clk_o (ref_clk)
    );

    // Whole next state; bus, DMA, select latch, recovery and precomp paths
    always_comb begin
        logic wr_fire;
        logic in_edge;
        logic out_edge;
        logic [7:0] wa;
        logic [7:0] ra;
        wr_fire  = 1'b0;
        in_edge  = 1'b0;
        out_edge = 1'b0;
        wa       = '0;
        ra       = '0;
        st_nxt = st_r;
        // Address and data may arrive in either order
        if (S_AXI_AWVALID_I && !st_r.aw_got) begin
            st_nxt.aw_got  = 1'b1;
            st_nxt.aw_addr = S_AXI_AWADDR_I;
        end
        if (S_AXI_WVALID_I && !st_r.w_got) begin
            st_nxt.w_got  = 1'b1;
            st_nxt.w_data = S_AXI_WDATA_I;
            st_nxt.w_strb = S_AXI_WSTRB_I;
        end
        if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
            wr_fire        = 1'b1;
            st_nxt.aw_got  = 1'b0;
            st_nxt.w_got   = 1'b0;
            st_nxt.bvalid  = 1'b1;
            st_nxt.bresp   = DDIS_RESP_OKAY;
            wa = 8'(st_r.aw_addr);
        end
        if (st_r.bvalid && S_AXI_BREADY_I) st_nxt.bvalid = 1'b0;
        // Select latch and control written here; upper bits dropped
        if (wr_fire) begin
            unique case (wa)
                DDIS_OFF_SELECT: begin
                    if (st_r.w_strb[0]) st_nxt.select[7:0] = st_r.w_data[7:0];
                    if (st_r.w_strb[1]) st_nxt.select[9:8] = st_r.w_data[9:8];
                end
                DDIS_OFF_DATA: begin
                    // Outbound byte for the controller core
                    if (st_r.w_strb[0]) begin
                        st_nxt.out_byte = st_r.w_data[7:0];
                        st_nxt.out_full = 1'b1;
                    end
                end
                DDIS_OFF_CONTROL: begin
                    if (st_r.w_strb[0]) st_nxt.control = st_r.w_data[2:0];
                end
                DDIS_OFF_STATUS: st_nxt.bresp = DDIS_RESP_OKAY;
                default:         st_nxt.bresp = DDIS_RESP_SLVERR;
            endcase
        end
        // Read channel; reading data empties the inbound holding stage
        if (S_AXI_ARVALID_I && !st_r.rvalid) begin
            ra = 8'(S_AXI_ARADDR_I);
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp  = DDIS_RESP_OKAY;
            unique case (ra)
                DDIS_OFF_SELECT:  st_nxt.rdata = {22'h0, st_r.select};
                DDIS_OFF_DATA: begin
                    st_nxt.rdata   = {24'h0, st_r.in_byte};
                    st_nxt.in_full = 1'b0;
                end
                DDIS_OFF_CONTROL: st_nxt.rdata = {29'h0, st_r.control};
                DDIS_OFF_STATUS:  st_nxt.rdata = {30'h0, st_r.out_full, st_r.in_full};
                default: begin
                    st_nxt.rdata = '0;
                    st_nxt.rresp = DDIS_RESP_SLVERR;
                end
            endcase
        end
        if (st_r.rvalid && S_AXI_RREADY_I) st_nxt.rvalid = 1'b0;
        // Strobe edges: byte moves on the trailing (rising) edge of a strobe
        st_nxt.in_strb_d  = INBOUND_DATA_STROBE_N_I;
        st_nxt.out_strb_d = OUTBOUND_DATA_STROBE_N_I;
        in_edge  = !st_r.in_strb_d && INBOUND_DATA_STROBE_N_I;
        out_edge = !st_r.out_strb_d && OUTBOUND_DATA_STROBE_N_I;
        // Inbound byte captured into a register, which wins over the read clear
        if (in_edge && !st_r.in_full && st_r.control[DDIS_CTL_INBOUND_BIT]) begin
            st_nxt.in_byte = BYTE_DATA_BUS_I;
            st_nxt.in_full = 1'b1;
        end
        // Outbound byte consumed; request drops until software refills; a refill wins
        if (out_edge && st_r.out_full && !(wr_fire && wa == DDIS_OFF_DATA && st_r.w_strb[0]))
            st_nxt.out_full = 1'b0;
        // Read recovery: edges of the encoded stream mark cells in the reference grid
        st_nxt.rd_prev = ENCODED_READ_PAIR_I;
        if (ENCODED_READ_PAIR_I != st_r.rd_prev) st_nxt.rd_seen = 1'b1;
        if ((ENCODED_READ_PAIR_I != st_r.rd_prev && st_r.cell_cnt > 4'(DDIS_CELL_CYCLES / 2))
            || st_r.cell_cnt == 4'(DDIS_CELL_CYCLES - 1)) begin
            st_nxt.cell_cnt = '0;
            st_nxt.rd_data  = st_r.rd_seen;
            st_nxt.rd_seen  = (ENCODED_READ_PAIR_I != st_r.rd_prev);
        end else begin
            st_nxt.cell_cnt = st_r.cell_cnt + 4'h1;
        end
        st_nxt.rd_clk = (st_r.cell_cnt < 4'(DDIS_CELL_CYCLES / 2));
        // Write path delay line, tapped by the core's pattern select
        st_nxt.wr_dly = {st_r.wr_dly[1:0], CORE_WRITE_DATA_I};
        if (!st_r.control[DDIS_CTL_PRECOMP_BIT]) begin
            st_nxt.wr_out = CORE_WRITE_DATA_I; // Bypass: no added delay
        end else begin
            st_nxt.wr_out = st_r.wr_dly[(PRECOMP_SELECT_I == 2'h3) ? 2'h2 : PRECOMP_SELECT_I];
        end
    end

    // Single state register; clock enable freezes everything
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            st_r            <= '0;
            st_r.select     <= DDIS_SELECT_RST;
            st_r.control    <= DDIS_CONTROL_RST;
            st_r.in_strb_d  <= 1'b1;
            st_r.out_strb_d <= 1'b1;
        end else if (CE_I) begin
            st_r <= st_nxt;
        end
    end

    // Bus handshake outputs
    assign S_AXI_AWREADY_O = !st_r.aw_got;
    assign S_AXI_WREADY_O  = !st_r.w_got;
    assign S_AXI_BVALID_O  = st_r.bvalid;
    assign S_AXI_BRESP_O   = st_r.bresp;
    assign S_AXI_ARREADY_O = !st_r.rvalid;
    assign S_AXI_RVALID_O  = st_r.rvalid;
    assign S_AXI_RDATA_O   = st_r.rdata;
    assign S_AXI_RRESP_O   = st_r.rresp;

    // Active-low open-collector select pins: low asserted, high released
    assign DRIVE_SELECT_N_O         = 1'b0;
    assign DRIVE_SELECT_N_OE_O      = !st_r.select[DDIS_SEL_DRIVE_BIT];
    assign HEAD_SELECT_LINES_N_O    = '0;
    assign HEAD_SELECT_LINES_N_OE_O = ~st_r.select[DDIS_HEAD_W-1:0];

    // Requests: low while a byte is wanted or waiting
    assign INBOUND_DATA_REQUEST_N_O  = !(st_r.control[DDIS_CTL_INBOUND_BIT] && !st_r.in_full);
    assign OUTBOUND_DATA_REQUEST_N_O = !(st_r.control[DDIS_CTL_OUTBOUND_BIT] && st_r.out_full);
    assign BYTE_DATA_BUS_O    = st_r.out_byte;
    assign BYTE_DATA_BUS_OE_O = !(st_r.control[DDIS_CTL_OUTBOUND_BIT] && st_r.out_full);

    assign READ_CLOCK_O         = st_r.rd_clk;
    assign READ_DATA_O          = st_r.rd_data;
    assign ENCODED_WRITE_PAIR_O = st_r.wr_out;
    assign WRITE_CLOCK_O        = wr_clk;
    assign REF_CLOCK_O          = ref_clk;

    a_out_req_drop: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        (CE_I && !st_r.out_strb_d && OUTBOUND_DATA_STROBE_N_I && st_r.out_full && !S_AXI_WVALID_I
         && !st_r.w_got) |=> OUTBOUND_DATA_REQUEST_N_O)
        else $error("outbound request held after strobe");
    a_in_capture: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        (CE_I && !st_r.in_strb_d && INBOUND_DATA_STROBE_N_I && !INBOUND_DATA_REQUEST_N_O)
        |=> (st_r.in_byte == $past(BYTE_DATA_BUS_I) && INBOUND_DATA_REQUEST_N_O))
        else $error("inbound byte not captured");
    // The edge that releases reset still sees reset state, so it starts no attempt
    a_precomp_bypass: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        (CE_I && !RST_I && !st_r.control[DDIS_CTL_PRECOMP_BIT])
        |=> (ENCODED_WRITE_PAIR_O == $past(CORE_WRITE_DATA_I)))
        else $error("write data delayed in bypass");
    a_sel_follow: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        (CE_I && st_r.aw_got && st_r.w_got && !st_r.bvalid && 8'(st_r.aw_addr) == DDIS_OFF_SELECT
         && &st_r.w_strb[1:0]) |=> (DRIVE_SELECT_N_OE_O == !$past(st_r.w_data[DDIS_SEL_DRIVE_BIT])
         && HEAD_SELECT_LINES_N_OE_O == ~$past(st_r.w_data[DDIS_HEAD_W-1:0])))
        else $error("drive select pin mismatch");
    a_bus_off_req: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        (CE_I && st_r.aw_got && st_r.w_got && !st_r.bvalid && 8'(st_r.aw_addr) == DDIS_OFF_DATA
         && st_r.w_strb[0] && st_r.control[DDIS_CTL_OUTBOUND_BIT]) |=> (!BYTE_DATA_BUS_OE_O
         && !OUTBOUND_DATA_REQUEST_N_O && BYTE_DATA_BUS_O == $past(st_r.w_data[7:0])))
        else $error("loaded byte not offered on the bus");
    a_write_resp: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        (CE_I && st_r.aw_got && st_r.w_got && !st_r.bvalid) |=> S_AXI_BVALID_O)
        else $error("write response missing");
    a_rd_clk_toggle: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        (CE_I && st_r.cell_cnt == 4'h0) ##1 CE_I |=> READ_CLOCK_O)
        else $error("read clock not high early in cell");
    a_precomp_tap: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        (CE_I && !RST_I && st_r.control[DDIS_CTL_PRECOMP_BIT] && PRECOMP_SELECT_I == 2'h0)
        |=> (ENCODED_WRITE_PAIR_O == $past(CORE_WRITE_DATA_I, 2)))
        else $error("precomp tap wrong");
endmodule
`default_nettype wire
